// >>> design/serial_pkg.sv
package serial_pkg;

  // register map, byte addresses on a 3-bit port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_CLEAR   = 3'h2;
  localparam logic [2:0] ADDR_ENABLE  = 3'h3;
  localparam logic [2:0] ADDR_BUFFER  = 3'h4;

  // control register fields
  localparam int unsigned CTRL_MODE1  = 6;
  localparam int unsigned CTRL_OPTION = 5;
  localparam int unsigned CTRL_RX_EN  = 4;
  localparam int unsigned CTRL_DOUBLE = 3;
  localparam int unsigned CTRL_NINTH  = 2;

  // status, clear and enable share this layout
  localparam int unsigned ST_TX = 1;
  localparam int unsigned ST_RX = 0;
  localparam logic [1:0]  FLAGS_NONE = 2'h0;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic       LINE_IDLE = 1'b1;
  localparam logic       START_BIT = 1'b0;
  localparam logic       STOP_BIT  = 1'b1;

  // mode 0 shift clock, in oscillator periods (one CLK each)
  localparam logic [3:0] M0_SLOW_LEAD   = 4'h3;
  localparam logic [3:0] M0_SLOW_LOW    = 4'h6;
  localparam logic [3:0] M0_SLOW_PERIOD = 4'hc;
  localparam logic [3:0] M0_FAST_LEAD   = 4'h1;
  localparam logic [3:0] M0_FAST_LOW    = 4'h2;
  localparam logic [3:0] M0_FAST_PERIOD = 4'h4;
  localparam logic [2:0] M0_LAST_BIT    = 3'h7;
  // pin flop plus two synchroniser flops
  localparam int unsigned PIN_LAG       = 3;

  // mode 1 divide-by-16 and vote slices
  localparam logic [3:0] DIV16_LAST  = 4'hf;
  localparam logic [3:0] VOTE_FIRST  = 4'h7;
  localparam logic [3:0] VOTE_SECOND = 4'h8;
  localparam logic [3:0] VOTE_THIRD  = 4'h9;
  localparam logic [3:0] M1_LAST_BIT = 4'h9;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic mode1;
    logic option;
    logic rx_en;
    logic double_rate;
  } ctrl_t;

  typedef enum logic [2:0] {
    M0_IDLE = 3'b001,
    M0_TX   = 3'b010,
    M0_RX   = 3'b100
  } m0_state_t;

  typedef enum logic [1:0] {
    TX1_IDLE = 2'b01,
    TX1_SEND = 2'b10
  } tx1_state_t;

  typedef enum logic [1:0] {
    RX1_HUNT  = 2'b01,
    RX1_FRAME = 2'b10
  } rx1_state_t;

  function automatic logic majority3(input logic a,
                                     input logic b,
                                     input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);

  logic meta;

  // idle serial line is high, so both stages reset high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> design/serial_port_modes_zero_one.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module serial_port_modes_zero_one
  import serial_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic       TIMER1_OVF,
  input  wire logic       RXD_IN,
  output logic      [7:0] RDATA,
  output logic            TXD,
  output logic            RXD_OUT,
  output logic            RXD_OE_N,
  output logic            IRQ
);

  bus_req_t   req;
  ctrl_t      ctrl;
  m0_state_t  m0_state;
  tx1_state_t tx1_state;
  rx1_state_t rx1_state;

  logic [1:0]       status;
  logic [1:0]       enable;
  logic [1:0]       set_mask;
  logic [1:0]       clear_mask;
  logic             ninth;
  logic [7:0]       tx_reg;
  logic [7:0]       rx_buf;
  logic             rxd_sync;
  logic             wr_buffer;

  logic [3:0]       m0_cnt;
  logic [3:0]       next_m0_cnt;
  logic [3:0]       m0_lead;
  logic [3:0]       m0_low;
  logic [3:0]       m0_period;
  logic [2:0]       m0_bit;
  logic [7:0]       m0_shift;
  logic             m0_end_bit;
  logic             m0_data;
  logic             sclk;
  logic             m0_rise;
  logic [PIN_LAG-1:0] rise_dly;
  logic [2:0]       m0_rx_cnt;
  logic [7:0]       m0_rx_shift;
  logic             m0_tx_done;
  logic             m0_rx_done;

  logic             half;
  logic             tick;
  logic [3:0]       tx_div;
  logic             roll;
  logic [9:0]       tx_frame;
  logic [3:0]       tx_idx;
  logic             tx_line;
  logic             m1_tx_done;

  logic [3:0]       rx_div;
  logic [3:0]       rx_idx;
  logic [1:0]       votes;
  logic             rx_prev;
  logic             rx_bit;
  logic             rx_decide;
  logic [7:0]       m1_rx_shift;
  logic             m1_rx_done;

  assign req = {ADDR, WDATA, WR, RD};
  assign wr_buffer = req.wr && (req.addr == ADDR_BUFFER);

  pin_sync u_rxd_sync
  (
    .clk     (CLK),
    .reset_n (RESET_N),
    .pin     (RXD_IN),
    .level   (rxd_sync)
  );

  // software registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl   <= '0;
      enable <= FLAGS_NONE;
    end
    else if (req.wr && req.addr == ADDR_CONTROL)
    begin
      ctrl.mode1       <= req.wdata[CTRL_MODE1];
      ctrl.option      <= req.wdata[CTRL_OPTION];
      ctrl.rx_en       <= req.wdata[CTRL_RX_EN];
      ctrl.double_rate <= req.wdata[CTRL_DOUBLE];
    end
    else if (req.wr && req.addr == ADDR_ENABLE)
    begin
      enable <= req.wdata[1:0];
    end
  end

  // transmit register is write-only; reads of the address see rx_buf
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      tx_reg <= BYTE_ZERO;
    else if (wr_buffer)
      tx_reg <= req.wdata;
  end

  // sticky flags: a hardware set in the clearing cycle survives
  always_comb
  begin
    set_mask          = FLAGS_NONE;
    set_mask[ST_TX]   = m0_tx_done | m1_tx_done;
    set_mask[ST_RX]   = m0_rx_done | m1_rx_done;
    clear_mask        = FLAGS_NONE;
    if (req.wr && req.addr == ADDR_CLEAR)
      clear_mask = req.wdata[1:0];
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      status <= FLAGS_NONE;
    else
      status <= (status & ~clear_mask) | set_mask;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(status & enable);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RDATA <= BYTE_ZERO;
    else if (req.rd)
    begin
      unique case (req.addr)
        ADDR_CONTROL: RDATA <= {1'b0, ctrl.mode1, ctrl.option, ctrl.rx_en,
                                ctrl.double_rate, ninth, status};
        ADDR_STATUS:  RDATA <= {6'h00, status};
        ADDR_ENABLE:  RDATA <= {6'h00, enable};
        ADDR_BUFFER:  RDATA <= rx_buf;
        default:      RDATA <= BYTE_ZERO;
      endcase
    end
    else
      RDATA <= BYTE_ZERO;
  end

  // mode 0 shift clock shape
  always_comb
  begin
    m0_lead   = ctrl.option ? M0_FAST_LEAD : M0_SLOW_LEAD;
    m0_low    = ctrl.option ? M0_FAST_LOW : M0_SLOW_LOW;
    m0_period = ctrl.option ? M0_FAST_PERIOD : M0_SLOW_PERIOD;
  end

  assign m0_end_bit  = (m0_cnt == m0_period - 4'h1);
  assign next_m0_cnt = m0_end_bit ? 4'h0 : m0_cnt + 4'h1;
  assign m0_rise     = (m0_state == M0_RX)
                       && (next_m0_cnt == m0_lead + m0_low);
  assign m0_tx_done  = (m0_state == M0_TX) && m0_end_bit
                       && (m0_bit == M0_LAST_BIT);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      m0_state <= M0_IDLE;
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_shift <= BYTE_ZERO;
      m0_data  <= LINE_IDLE;
      sclk     <= LINE_IDLE;
    end
    else
    begin
      unique case (m0_state)
        M0_IDLE:
        begin
          m0_cnt  <= 4'h0;
          m0_bit  <= 3'h0;
          sclk    <= LINE_IDLE;
          m0_data <= LINE_IDLE;
          if (!ctrl.mode1 && wr_buffer)
          begin
            m0_state <= M0_TX;
            m0_shift <= req.wdata;
            m0_data  <= req.wdata[0];
          end
          // a late sample of the last frame must land before restarting
          else if (!ctrl.mode1 && ctrl.rx_en && !status[ST_RX]
                   && rise_dly == '0)
            m0_state <= M0_RX;
        end
        M0_TX, M0_RX:
        begin
          m0_cnt <= next_m0_cnt;
          sclk   <= !(next_m0_cnt >= m0_lead
                      && next_m0_cnt < m0_lead + m0_low);
          if (ctrl.mode1)
            m0_state <= M0_IDLE;
          else if (m0_end_bit)
          begin
            m0_bit <= m0_bit + 3'h1;
            if (m0_bit == M0_LAST_BIT)
              m0_state <= M0_IDLE;
            else if (m0_state == M0_TX)
            begin
              m0_shift <= {1'b0, m0_shift[7:1]};
              m0_data  <= m0_shift[1];
            end
          end
        end
      endcase
    end
  end

  // sample where the rise is seen back at the pin, past pin and sync flops
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rise_dly    <= '0;
      m0_rx_cnt   <= 3'h0;
      m0_rx_shift <= BYTE_ZERO;
    end
    else
    begin
      rise_dly <= {rise_dly[PIN_LAG-2:0], m0_rise};
      if (rise_dly[PIN_LAG-1])
      begin
        m0_rx_shift <= {rxd_sync, m0_rx_shift[7:1]};
        m0_rx_cnt   <= m0_rx_cnt + 3'h1;
      end
    end
  end

  assign m0_rx_done = rise_dly[PIN_LAG-1] && (m0_rx_cnt == M0_LAST_BIT);

  // mode 1 sample tick: timer overflow, halved unless double rate
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      half <= 1'b0;
    else if (TIMER1_OVF)
      half <= ~half;
  end

  assign tick = TIMER1_OVF && (ctrl.double_rate || half);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      tx_div <= 4'h0;
    else if (tick)
      tx_div <= tx_div + 4'h1;
  end

  assign roll       = tick && (tx_div == DIV16_LAST);
  assign m1_tx_done = (tx1_state == TX1_SEND) && roll
                      && (tx_idx == M1_LAST_BIT);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tx1_state <= TX1_IDLE;
      tx_frame  <= '1;
      tx_idx    <= 4'h0;
      tx_line   <= LINE_IDLE;
    end
    else
    begin
      unique case (tx1_state)
        TX1_IDLE:
        begin
          if (ctrl.mode1 && wr_buffer)
          begin
            tx1_state <= TX1_SEND;
            tx_frame  <= {STOP_BIT, req.wdata, START_BIT};
            tx_idx    <= 4'h0;
          end
        end
        TX1_SEND:
        begin
          if (!ctrl.mode1)
          begin
            tx1_state <= TX1_IDLE;
            tx_line   <= LINE_IDLE;
          end
          else if (roll)
          begin
            tx_line  <= tx_frame[0];
            tx_frame <= {LINE_IDLE, tx_frame[9:1]};
            tx_idx   <= tx_idx + 4'h1;
            if (tx_idx == M1_LAST_BIT)
              tx1_state <= TX1_IDLE;
          end
        end
      endcase
    end
  end

  assign rx_decide = (rx1_state == RX1_FRAME) && tick
                     && (rx_div == VOTE_THIRD);
  assign rx_bit    = majority3(votes[0], votes[1], rxd_sync);
  assign m1_rx_done = rx_decide && (rx_idx == M1_LAST_BIT)
                      && !status[ST_RX]
                      && (!ctrl.option || rx_bit);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx1_state   <= RX1_HUNT;
      rx_div      <= 4'h0;
      rx_idx      <= 4'h0;
      votes       <= 2'h0;
      rx_prev     <= LINE_IDLE;
      m1_rx_shift <= BYTE_ZERO;
    end
    else if (!ctrl.mode1 || !ctrl.rx_en)
    begin
      rx1_state <= RX1_HUNT;
      rx_prev   <= LINE_IDLE;
    end
    else if (tick)
    begin
      unique case (rx1_state)
        RX1_HUNT:
        begin
          rx_prev <= rxd_sync;
          if (rx_prev && !rxd_sync)
          begin
            rx1_state <= RX1_FRAME;
            rx_div    <= 4'h0;
            rx_idx    <= 4'h0;
          end
        end
        RX1_FRAME:
        begin
          rx_div <= rx_div + 4'h1;
          if (rx_div == VOTE_FIRST)
            votes[0] <= rxd_sync;
          if (rx_div == VOTE_SECOND)
            votes[1] <= rxd_sync;
          if (rx_div == VOTE_THIRD)
          begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == 4'h0 && rx_bit != START_BIT)
            begin
              rx1_state <= RX1_HUNT;
              rx_prev   <= rxd_sync;
            end
            else if (rx_idx == M1_LAST_BIT)
            begin
              // mid stop bit: hunt again, line seen as it is now
              rx1_state <= RX1_HUNT;
              rx_prev   <= rxd_sync;
            end
            else if (rx_idx != 4'h0)
              m1_rx_shift <= {rx_bit, m1_rx_shift[7:1]};
          end
        end
      endcase
    end
  end

  // receive buffer and ninth bit
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx_buf <= BYTE_ZERO;
      ninth  <= 1'b0;
    end
    else if (m0_rx_done)
      rx_buf <= {rxd_sync, m0_rx_shift[7:1]};
    else if (m1_rx_done)
    begin
      rx_buf <= m1_rx_shift;
      ninth  <= rx_bit;
    end
  end

  // pins: mode 0 drives data on RXD and the shift clock on TXD
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TXD      <= LINE_IDLE;
      RXD_OUT  <= LINE_IDLE;
      RXD_OE_N <= 1'b1;
    end
    else
    begin
      TXD      <= ctrl.mode1 ? tx_line : sclk;
      RXD_OUT  <= m0_data;
      RXD_OE_N <= !(m0_state == M0_TX);
    end
  end

endmodule

`default_nettype wire

// >>> testbench/serial_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_sva
  import serial_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic       TIMER1_OVF,
  input wire logic [7:0] RDATA,
  input wire logic       TXD,
  input wire logic       RXD_OUT,
  input wire logic       RXD_OE_N,
  input wire logic       IRQ
);
  logic m1;
  logic opt;
  logic fast;
  logic slow;

  // mode bits mirrored from control writes, ports only
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      m1  <= 1'b0;
      opt <= 1'b0;
    end
    else if (WR && ADDR == ADDR_CONTROL)
    begin
      m1  <= WDATA[CTRL_MODE1];
      opt <= WDATA[CTRL_OPTION];
    end

  assign fast = !m1 && opt;
  assign slow = !m1 && !opt;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_idle;
    $rose(RESET_N) |-> TXD && RXD_OE_N && !IRQ && RDATA == BYTE_ZERO;
  endproperty
  a_idle: assert property (p_idle)
    else $error("outputs not idle after reset");

  property p_rdata;
    !$past(RD) |-> RDATA == BYTE_ZERO;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");

  property p_low_fast;
    fast && $fell(TXD) |-> ##1 !TXD ##1 TXD;
  endproperty
  a_low_fast: assert property (p_low_fast)
    else $error("fast shift clock low time wrong");

  property p_low_slow;
    slow && $fell(TXD) |-> ##1 !TXD [*5] ##1 TXD;
  endproperty
  a_low_slow: assert property (p_low_slow)
    else $error("slow shift clock low time wrong");

  property p_high_fast;
    fast && $rose(TXD) |-> TXD [*2];
  endproperty
  a_high_fast: assert property (p_high_fast)
    else $error("fast shift clock high too short");

  property p_high_slow;
    slow && $rose(TXD) |-> TXD [*6];
  endproperty
  a_high_slow: assert property (p_high_slow)
    else $error("slow shift clock high too short");

  // the last bit may be followed by release instead of a fall
  property p_lead_fast;
    fast && !RXD_OE_N && $changed(RXD_OUT) |-> ##1 (!TXD || RXD_OE_N);
  endproperty
  a_lead_fast: assert property (p_lead_fast)
    else $error("data lead before clock fall wrong");

  property p_m1_edges;
    m1 && $changed(TXD) |->
      $past(TIMER1_OVF) || $past(TIMER1_OVF, 2) || $past(TIMER1_OVF, 3);
  endproperty
  a_m1_edges: assert property (p_m1_edges)
    else $error("mode 1 line changed away from a rollover");
endmodule

bind serial_port_modes_zero_one serial_port_sva u_sva
(
  .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .TIMER1_OVF(TIMER1_OVF), .RDATA(RDATA), .TXD(TXD),
  .RXD_OUT(RXD_OUT), .RXD_OE_N(RXD_OE_N), .IRQ(IRQ)
);
`default_nettype wire

// >>> testbench/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none
module serial_peer
#(
  parameter int BIT_NS = 3200
)
(
  input  wire logic       txd,
  input  wire logic       rxd_out,
  input  wire logic       rxd_oe_n,
  input  wire logic       mode1,
  output logic            line,
  output logic      [7:0] got,
  output logic      [9:0] frame
);
  logic [7:0] sh;
  logic [3:0] n;

  initial
  begin
    line = 1'b1;
    n    = 4'h0;
  end

  task automatic arm0(input logic [7:0] b);
    sh = b;
    n  = 4'h8;
  endtask

  always @(negedge txd)
    if (!mode1 && rxd_oe_n && n != 4'h0)
    begin
      line = sh[0];
      sh   = sh >> 1;
      n    = n - 4'h1;
    end

  // release after a hold, the synchroniser still needs the last bit
  always @(posedge txd)
    if (!mode1 && !rxd_oe_n)
      got = {rxd_out, got[7:1]};
    else if (!mode1 && n == 4'h0)
      line <= #100 1'b1;

  always @(negedge txd)
    if (mode1)
    begin
      #(BIT_NS / 2);
      for (int i = 0; i < 10; i++)
      begin
        frame[i] = txd;
        #(BIT_NS);
      end
    end

  task automatic send1(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line = f[i];
      #(BIT_NS);
    end
    line = 1'b1;
  endtask

  task automatic pulse(input int ns);
    line = 1'b0;
    #(ns);
    line = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/serial_port_modes_zero_one_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_modes_zero_one_tb_top
  import serial_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ovf = 1'b0;
  logic [2:0] div = 3'h0;
  wire        rxd_in;
  logic [7:0] rdata;
  logic       txd;
  logic       rxd_out;
  logic       rxd_oe_n;
  logic       irq;
  logic       line;
  logic       mode1;
  logic [7:0] got;
  logic [9:0] frame;
  int         n_mismatch;
  int         n_compared;

  assign rxd_in = rxd_oe_n ? line : rxd_out;

  serial_port_modes_zero_one DUT
  (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .TIMER1_OVF(ovf), .RXD_IN(rxd_in), .RDATA(rdata),
    .TXD(txd), .RXD_OUT(rxd_out), .RXD_OE_N(rxd_oe_n), .IRQ(irq)
  );

  serial_peer peer
  (
    .txd(txd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .mode1(mode1),
    .line(line), .got(got), .frame(frame)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one overflow every 8 clocks, so one bit is 128 clocks at double rate
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    ovf <= (div == 3'h7);
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_flag(input int b);
    logic [7:0] v;
    v = BYTE_ZERO;
    for (int i = 0; i < 4000 && v[b] !== 1'b1; i++)
      rd_reg(ADDR_STATUS, v);
    check(v[b], 1'b1);
  endtask

  task automatic irq_step(input logic [2:0] a, input logic [7:0] d,
                          input logic e);
    wr_reg(a, d);
    repeat (3) @(posedge clk);
    check(irq, e);
  endtask

  task automatic t_reset();
    logic [7:0] v;
    check({txd, rxd_oe_n, irq}, 3'b110);
    wr_reg(3'h5, 8'hff);
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(3'(a), v);
      check(v, BYTE_ZERO);
    end
  endtask

  task automatic t_mode0_tx();
    logic [7:0] v;
    for (int o = 1; o >= 0; o--)
    begin
      wr_reg(ADDR_CONTROL, 8'(o << CTRL_OPTION));
      wr_reg(ADDR_BUFFER, 8'ha5 ^ 8'(o));
      wait_flag(ST_TX);
      check(got, 8'ha5 ^ 8'(o));
      repeat (50) @(posedge clk);
      rd_reg(ADDR_CONTROL, v);
      check(v[1], 1'b1);
      wr_reg(ADDR_CLEAR, 8'h02);
      rd_reg(ADDR_STATUS, v);
      check(v, BYTE_ZERO);
    end
  endtask

  task automatic t_irq();
    wr_reg(ADDR_ENABLE, 8'h02);
    wr_reg(ADDR_BUFFER, 8'h3c);
    wait_flag(ST_TX);
    irq_step(ADDR_ENABLE, 8'h01, 1'b0);
    irq_step(ADDR_ENABLE, 8'h03, 1'b1);
    irq_step(ADDR_CLEAR, 8'h03, 1'b0);
    irq_step(ADDR_ENABLE, 8'h00, 1'b0);
  endtask

  task automatic t_mode0_rx();
    logic [7:0] v;
    logic [9:0] n;
    peer.arm0(8'h96);
    wr_reg(ADDR_CONTROL, 8'h30);
    wait_flag(ST_RX);
    rd_reg(ADDR_BUFFER, v);
    check(v, 8'h96);
    n = 10'h000;
    repeat (100) @(posedge clk) if (txd !== 1'b1) n++;
    check(n, 10'h000);
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_CLEAR, 8'h01);
  endtask

  task automatic t_mode1_tx();
    logic [7:0] v;
    longint     t0;
    mode1 = 1'b1;
    wr_reg(ADDR_CONTROL, 8'h48);
    wr_reg(ADDR_BUFFER, 8'h5b);
    t0 = $time;
    rd_reg(ADDR_BUFFER, v);
    check(v, 8'h96);
    wait_flag(ST_TX);
    // ten rollovers of 128 clocks, the first one partial
    check(($time - t0) / 25 > 1150 && ($time - t0) / 25 < 1300, 1'b1);
    repeat (150) @(posedge clk);
    check(frame, {1'b1, 8'h5b, 1'b0});
    wr_reg(ADDR_CLEAR, 8'h02);
    // single rate: a tick every second overflow, rollover every 256 clocks
    wr_reg(ADDR_CONTROL, 8'h40);
    wr_reg(ADDR_BUFFER, 8'ha6);
    t0 = $time;
    wait_flag(ST_TX);
    check(($time - t0) / 25 > 2300 && ($time - t0) / 25 < 2600, 1'b1);
    repeat (300) @(posedge clk);
    wr_reg(ADDR_CLEAR, 8'h02);
  endtask

  task automatic t_mode1_rx();
    logic [7:0] v;
    wr_reg(ADDR_CONTROL, 8'h58);
    peer.pulse(1000);
    #3000;
    peer.send1(8'hc3, 1'b1);
    wait_flag(ST_RX);
    rd_reg(ADDR_BUFFER, v);
    check(v, 8'hc3);
    rd_reg(ADDR_CONTROL, v);
    check(v[CTRL_NINTH], 1'b1);
    peer.send1(8'h11, 1'b1);
    rd_reg(ADDR_BUFFER, v);
    check(v, 8'hc3);
    wr_reg(ADDR_CLEAR, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h78);
    peer.send1(8'h22, 1'b0);
    rd_reg(ADDR_STATUS, v);
    check(v, BYTE_ZERO);
    // send1 raises the line only as it returns after a low stop bit; idle one bit so an edge is seen
    #3200;
    peer.send1(8'h44, 1'b1);
    wait_flag(ST_RX);
    rd_reg(ADDR_BUFFER, v);
    check(v, 8'h44);
  endtask

  initial
  begin
    #2_000_000;
    n_mismatch++;
    results();
  end

  initial
  begin
    reset_n = 1'b0;
    addr = 3'h0;
    wdata = BYTE_ZERO;
    wr = 1'b0;
    rd = 1'b0;
    mode1 = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_mode0_tx();
    t_irq();
    t_mode0_rx();
    t_mode1_tx();
    t_mode1_rx();
    results();
  end
endmodule
`default_nettype wire
